// File: tps_timer_front.sv
// Timer clock select, prescaler control, counter and flag registers.
// Assumes a CPU register port on the same clock and an asynchronous count pin.
//
// How it works
// - Select code one ticks on every system clock while the prescaler reset bit is clear.
// - Codes two to five tick from divide by 8, 64, 256, 1024 taps.
// - Select code zero gives no ticks; the timer stops.
// - Prescaler runs freely whatever the select code.
// - First prescaled tick comes 1 to N+1 cycles after enabling.
// - Pin sampled each cycle: high-phase latch then rising-edge registers.
// - One tick per rising edge at code seven, falling at six.
// - Pin edge reaches the counter 2.5 to 3.5 cycles later.
// - Pin ticks never pass through the prescaler.
// - Sync hold set keeps the prescaler reset bit as written.
// - Sync hold cleared makes hardware clear the prescaler reset bit.
// - Prescaler reset bit resets prescaler, self-clears unless held.
// - Pin transitions count even when the pin is driven as output.
// - Counter low byte and compares are 8 bits; high byte for 16-bit.
// - In 16-bit mode compare B is high byte, A low byte.
// - Two compare units in 8-bit mode, one in 16-bit mode.
// - Four interrupt flags, each gated by its own mask bit.
// - CPU counter write beats any count that cycle; always accessible.
// - Counter advances one per tick; idle with no source.
//
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/100ps
module tps_timer_front (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic count_pin,
    input wire logic capture_event,
    output logic timer_tick,
    output logic [15:0] count_value,
    output logic [3:0] int_request
);

    // ********************************************************
    // Declarations
    // ********************************************************
    logic [7:0] control_a_q;
    logic sync_hold_mode_q;
    logic prescaler_reset_bit_q;
    logic [2:0] tick_source_select_q;
    logic [15:0] count_q;
    logic [15:0] count_d;
    logic [7:0] compare_reg_a_q;
    logic [7:0] compare_reg_b_q;
    logic [3:0] timer_int_flags_q;
    logic [3:0] timer_int_masks_q;
    logic [7:0] rdata_q;
    logic tick_d;
    logic tick_q;
    logic wide_mode;
    logic count_write;
    logic overflow_event;
    logic compare_a_event;
    logic compare_b_event;
    logic [3:0] flag_set;
    logic [3:0] flag_clear;
    logic control_b_write;
    logic [7:0] rdata_d;
    logic count_at_max;
    logic [15:0] compare_word;

    tps_tick_if ticks ();

    assign wide_mode = control_a_q[tps_pkg::WIDE_MODE_BIT];

    // ********************************************************
    // Tick sources
    // ********************************************************
    // prescaler cleared only by its reset bit
    // taps keep their phase, so a first tick lands within N+1 cycles
    tps_prescaler #(
        .WIDTH(tps_pkg::PRESCALER_WIDTH)
    ) u_prescaler (
        .clock(clock),
        .reset_n(reset_n),
        .prescaler_clear(prescaler_reset_bit_q),
        .ticks(ticks.prescaler)
    );

    // pin passes a latch stage and two registers first
    // pin level read regardless of its direction
    tps_pin_sampler u_pin_sampler (
        .clock(clock),
        .reset_n(reset_n),
        .count_pin(count_pin),
        .ticks(ticks.pin_sampler)
    );

    // ********************************************************
    // Clock select
    // ********************************************************
    // Direct ticks wait on the prescaler reset too, so hold halts all internal sources
    always_comb
    begin
        tick_d = 1'b0;
        unique case (tick_source_select_q)
            tps_pkg::SEL_STOPPED:
                tick_d = 1'b0;
            tps_pkg::SEL_DIRECT:
                tick_d = !prescaler_reset_bit_q;
            tps_pkg::SEL_DIV8:
                tick_d = ticks.tap_pulse[0];
            tps_pkg::SEL_DIV64:
                tick_d = ticks.tap_pulse[1];
            tps_pkg::SEL_DIV256:
                tick_d = ticks.tap_pulse[2];
            tps_pkg::SEL_DIV1024:
                tick_d = ticks.tap_pulse[3];
            tps_pkg::SEL_PIN_FALL:
                tick_d = ticks.pin_fall;
            tps_pkg::SEL_PIN_RISE:
                tick_d = ticks.pin_rise;
        endcase
    end

    // extra stage sets pin delay to 2.5-3.5 cycles
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            tick_q <= 1'b0;
        else
            tick_q <= tick_d;
    end

    assign timer_tick = tick_q;

    // ********************************************************
    // Control registers
    // ********************************************************
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            control_a_q <= tps_pkg::CONTROL_A_RESET;
        else if (reg_write && reg_addr == tps_pkg::ADDR_CONTROL_A)
            control_a_q <= reg_wdata;
    end

    assign control_b_write = reg_write && reg_addr == tps_pkg::ADDR_CONTROL_B;

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            sync_hold_mode_q <= tps_pkg::CONTROL_B_RESET[tps_pkg::SYNC_HOLD_BIT];
        else if (control_b_write)
            sync_hold_mode_q <= reg_wdata[tps_pkg::SYNC_HOLD_BIT];
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            tick_source_select_q <= tps_pkg::CONTROL_B_RESET[tps_pkg::SELECT_MSB:0];
        else if (control_b_write)
            // safe only while the pin is steady
            tick_source_select_q <= reg_wdata[tps_pkg::SELECT_MSB:0];
    end

    // Prescaler reset bit: written value lives one cycle unless held
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            prescaler_reset_bit_q <= tps_pkg::CONTROL_B_RESET[tps_pkg::PRESCALER_RESET_BIT];
        else if (control_b_write)
            prescaler_reset_bit_q <= reg_wdata[tps_pkg::PRESCALER_RESET_BIT];
        else if (!sync_hold_mode_q)
            prescaler_reset_bit_q <= 1'b0;
        else
            prescaler_reset_bit_q <= prescaler_reset_bit_q;
    end

    // ********************************************************
    // Counter
    // ********************************************************
    // Either byte written counts as a CPU write
    assign count_write = reg_write
        && (reg_addr == tps_pkg::ADDR_COUNT_LOW || reg_addr == tps_pkg::ADDR_COUNT_HIGH);

    always_comb
    begin
        count_d = count_q;
        if (count_write)
        begin
            if (reg_addr == tps_pkg::ADDR_COUNT_LOW)
                count_d[7:0] = reg_wdata;
            else
                count_d[15:8] = reg_wdata;
        end
        else if (tick_q)
        begin
            if (wide_mode)
                count_d = count_q + 16'h0001;
            // 8-bit mode leaves the high byte alone
            else
                count_d[7:0] = count_q[7:0] + 8'h01;
        end
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            count_q <= tps_pkg::COUNT_RESET;
        else
            count_q <= count_d;
    end

    assign count_value = count_q;

    // ********************************************************
    // Compare registers
    // ********************************************************
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            compare_reg_a_q <= tps_pkg::COMPARE_RESET;
            compare_reg_b_q <= tps_pkg::COMPARE_RESET;
        end
        else if (reg_write)
        begin
            if (reg_addr == tps_pkg::ADDR_COMPARE_A)
                compare_reg_a_q <= reg_wdata;
            if (reg_addr == tps_pkg::ADDR_COMPARE_B)
                compare_reg_b_q <= reg_wdata;
        end
    end

    // ********************************************************
    // Events
    // ********************************************************
    // Overflow and compare events only on counting cycles, so a written match raises nothing
    // top is FF in 8-bit mode, FFFF when wide
    assign count_at_max = wide_mode ? (count_q == 16'hFFFF) : (count_q[7:0] == 8'hFF);

    assign overflow_event = tick_q && !count_write && count_at_max;

    // B high byte, A low byte
    assign compare_word = {compare_reg_b_q, compare_reg_a_q};

    // one unit when wide, two otherwise
    assign compare_a_event = tick_q && !count_write
        && (wide_mode ? (count_d == compare_word)
                      : (count_d[7:0] == compare_reg_a_q));

    assign compare_b_event = tick_q && !count_write && !wide_mode
        && (count_d[7:0] == compare_reg_b_q);

    always_comb
    begin
        flag_set = 4'h0;
        flag_set[tps_pkg::OVERFLOW_BIT] = overflow_event;
        flag_set[tps_pkg::COMPARE_A_BIT] = compare_a_event;
        flag_set[tps_pkg::COMPARE_B_BIT] = compare_b_event;
        flag_set[tps_pkg::CAPTURE_BIT] = capture_event;
    end

    // ********************************************************
    // Interrupt flags and masks
    // ********************************************************
    assign flag_clear = (reg_write && reg_addr == tps_pkg::ADDR_INT_FLAGS)
        ? reg_wdata[3:0] : 4'h0;

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            timer_int_flags_q <= tps_pkg::FLAGS_RESET;
        else
            timer_int_flags_q <= (timer_int_flags_q & ~flag_clear) | flag_set;
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            timer_int_masks_q <= tps_pkg::FLAGS_RESET;
        else if (reg_write && reg_addr == tps_pkg::ADDR_INT_MASKS)
            timer_int_masks_q <= reg_wdata[3:0];
    end

    assign int_request = timer_int_flags_q & timer_int_masks_q;

    // ********************************************************
    // Read port
    // ********************************************************
    // Counter reads show live bytes; no shadow latch for 16-bit reads
    always_comb
    begin
        rdata_d = 8'h00;
        unique case (reg_addr)
            tps_pkg::ADDR_CONTROL_A:
                rdata_d = control_a_q;
            tps_pkg::ADDR_CONTROL_B:
                rdata_d = {3'h0, sync_hold_mode_q, prescaler_reset_bit_q,
                           tick_source_select_q};
            tps_pkg::ADDR_COUNT_LOW:
                rdata_d = count_q[7:0];
            tps_pkg::ADDR_COUNT_HIGH:
                rdata_d = count_q[15:8];
            tps_pkg::ADDR_COMPARE_A:
                rdata_d = compare_reg_a_q;
            tps_pkg::ADDR_COMPARE_B:
                rdata_d = compare_reg_b_q;
            tps_pkg::ADDR_INT_FLAGS:
                rdata_d = {4'h0, timer_int_flags_q};
            tps_pkg::ADDR_INT_MASKS:
                rdata_d = {4'h0, timer_int_masks_q};
        endcase
    end

    // Idle cycles read zero, so stale data never looks valid
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            rdata_q <= 8'h00;
        else if (reg_read)
            rdata_q <= rdata_d;
        else
            rdata_q <= 8'h00;
    end

    assign reg_rdata = rdata_q;

endmodule // tps_timer_front

// File: tps_pkg.sv
// Constants shared by the timer clock-select front end and its helpers.
// Assumes an 8-bit register port and a single 50 MHz system clock.
package tps_pkg;

    // ********************************************************
    // Register addresses
    // ********************************************************
    localparam logic [2:0] ADDR_CONTROL_A = 3'h0;
    localparam logic [2:0] ADDR_CONTROL_B = 3'h1;
    localparam logic [2:0] ADDR_COUNT_LOW = 3'h2;
    localparam logic [2:0] ADDR_COUNT_HIGH = 3'h3;
    localparam logic [2:0] ADDR_COMPARE_A = 3'h4;
    localparam logic [2:0] ADDR_COMPARE_B = 3'h5;
    localparam logic [2:0] ADDR_INT_FLAGS = 3'h6;
    localparam logic [2:0] ADDR_INT_MASKS = 3'h7;

    // ********************************************************
    // Field positions
    // ********************************************************
    localparam int WIDE_MODE_BIT = 7;
    localparam int SYNC_HOLD_BIT = 4;
    localparam int PRESCALER_RESET_BIT = 3;
    localparam int SELECT_MSB = 2;
    localparam int OVERFLOW_BIT = 0;
    localparam int COMPARE_A_BIT = 1;
    localparam int COMPARE_B_BIT = 2;
    localparam int CAPTURE_BIT = 3;

    // ********************************************************
    // Values after reset
    // ********************************************************
    localparam logic [7:0] CONTROL_A_RESET = 8'h00;
    localparam logic [7:0] CONTROL_B_RESET = 8'h00;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [7:0] COMPARE_RESET = 8'h00;
    localparam logic [3:0] FLAGS_RESET = 4'h0;

    // ********************************************************
    // Tick source select codes
    // ********************************************************
    localparam logic [2:0] SEL_STOPPED = 3'h0;
    localparam logic [2:0] SEL_DIRECT = 3'h1;
    localparam logic [2:0] SEL_DIV8 = 3'h2;
    localparam logic [2:0] SEL_DIV64 = 3'h3;
    localparam logic [2:0] SEL_DIV256 = 3'h4;
    localparam logic [2:0] SEL_DIV1024 = 3'h5;
    localparam logic [2:0] SEL_PIN_FALL = 3'h6;
    localparam logic [2:0] SEL_PIN_RISE = 3'h7;

    // ********************************************************
    // Prescaler taps: log2 of each divisor
    // ********************************************************
    localparam int TAP_COUNT = 4;
    localparam int PRESCALER_WIDTH = 10;
    localparam int TAP_LOG2_DIV8 = 3;
    localparam int TAP_LOG2_DIV64 = 6;
    localparam int TAP_LOG2_DIV256 = 8;
    localparam int TAP_LOG2_DIV1024 = 10;

endpackage

// File: tps_tick_if.sv
// Carries tick candidates from the prescaler and pin sampler to the core.
// All signals are one-cycle pulses on the system clock.
`timescale 1ns/100ps
interface tps_tick_if;

    logic [tps_pkg::TAP_COUNT-1:0] tap_pulse;
    logic pin_rise;
    logic pin_fall;

    modport prescaler
    (
        output tap_pulse
    );

    modport pin_sampler
    (
        output pin_rise,
        output pin_fall
    );

    modport core
    (
        input tap_pulse,
        input pin_rise,
        input pin_fall
    );

endinterface

// File: tps_prescaler.sv
// Free-running system clock prescaler with four tap pulses.
// Assumes the reset request comes from logic on the same clock.
`timescale 1ns/100ps
module tps_prescaler #(
    parameter int WIDTH = tps_pkg::PRESCALER_WIDTH
)(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic prescaler_clear,
    tps_tick_if.prescaler ticks
);

    logic [WIDTH-1:0] div_q;

    // ********************************************************
    // Divider
    // ********************************************************
    // runs regardless of select
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            div_q <= '0;
        else if (prescaler_clear)
            div_q <= '0;
        else
            div_q <= div_q + 1'b1;
    end

    // ********************************************************
    // Taps
    // ********************************************************
    localparam int TAP_LOG2 [tps_pkg::TAP_COUNT] = '{
        tps_pkg::TAP_LOG2_DIV8,
        tps_pkg::TAP_LOG2_DIV64,
        tps_pkg::TAP_LOG2_DIV256,
        tps_pkg::TAP_LOG2_DIV1024
    };

    genvar g;
    generate
        for (g = 0; g < tps_pkg::TAP_COUNT; g++)
        begin : g_tap
            assign ticks.tap_pulse[g] = !prescaler_clear && (&div_q[TAP_LOG2[g]-1:0]);
        end
    endgenerate

endmodule // tps_prescaler

// File: tps_pin_sampler.sv
// Samples the external count pin and flags its rising and falling edges.
// Assumes the pin is asynchronous to the system clock.
`timescale 1ns/100ps
module tps_pin_sampler (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic count_pin,
    tps_tick_if.pin_sampler ticks
);

    logic low_phase_q;
    logic sync_q;
    logic last_q;

    // ********************************************************
    // Synchroniser
    // ********************************************************
    // latch open while clock high
    // Falling-edge capture equals a latch open during the high phase
    always_ff @(negedge clock or negedge reset_n)
    begin
        if (!reset_n)
            low_phase_q <= 1'b0;
        else
            low_phase_q <= count_pin;
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sync_q <= 1'b0;
            last_q <= 1'b0;
        end
        else
        begin
            sync_q <= low_phase_q;
            last_q <= sync_q;
        end
    end

    // ********************************************************
    // Edge detector
    // ********************************************************
    // one pulse per edge
    assign ticks.pin_rise = sync_q && !last_q;
    assign ticks.pin_fall = !sync_q && last_q;

endmodule // tps_pin_sampler

// File: tps_front_assertions.sv
// Port checks for the timer clock-select front end.
// Assumes registers change only through the register port.
`timescale 1ns/100ps
module tps_front_assertions (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic count_pin,
    input wire logic capture_event,
    input wire logic timer_tick,
    input wire logic [15:0] count_value,
    input wire logic [3:0] int_request
);
    // ********************
    // Register shadows
    // ********************
    logic [2:0] sel_q;
    logic psr_q;
    logic hold_q;
    logic [3:0] mask_q;
    logic cnt_wr;

    assign cnt_wr = reg_write && reg_addr[2:1] == 2'b01;

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sel_q <= 3'h0;
            psr_q <= 1'b0;
            hold_q <= 1'b0;
        end
        else if (reg_write && reg_addr == tps_pkg::ADDR_CONTROL_B)
        begin
            sel_q <= reg_wdata[2:0];
            psr_q <= reg_wdata[3];
            hold_q <= reg_wdata[4];
        end
        else if (!hold_q)
            psr_q <= 1'b0;
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            mask_q <= 4'h0;
        else if (reg_write && reg_addr == tps_pkg::ADDR_INT_MASKS)
            mask_q <= reg_wdata[3:0];
    end

    // ********************
    // Properties
    // ********************
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    sequence s_pin_edge;
        (sel_q == tps_pkg::SEL_PIN_RISE && $rose(count_pin))
            || (sel_q == tps_pkg::SEL_PIN_FALL && $fell(count_pin));
    endsequence

    // Six quiet cycles outlast the pin pipeline
    sequence s_pin_quiet;
        (sel_q[2:1] == 2'b11 && $stable(count_pin)) [*6];
    endsequence

    a_count_step: assert property (timer_tick && !cnt_wr
        |=> count_value[7:0] == $past(count_value[7:0]) + 8'h01)
        else $error("counter did not advance on a tick");
    a_count_hold: assert property (!timer_tick && !cnt_wr
        |=> $stable(count_value))
        else $error("counter moved without a tick");
    a_write_wins: assert property (reg_write && reg_addr == 3'h2
        |=> count_value[7:0] == $past(reg_wdata))
        else $error("counter write lost to a count");
    a_tick_stopped: assert property ($past(sel_q) == 3'h0 && sel_q == 3'h0
        |-> !timer_tick)
        else $error("tick while stopped");
    a_direct_tick: assert property ($past(sel_q) == 3'h1 && $past(sel_q, 2) == 3'h1
        && $past(psr_q) == $past(psr_q, 2) |-> timer_tick == !$past(psr_q))
        else $error("direct tick wrong for reset bit state");
    a_div8_gap: assert property (timer_tick && sel_q == 3'h2 && $past(sel_q) == 3'h2
        |=> !timer_tick [*7])
        else $error("divide by 8 tick came early");
    a_mask_gate: assert property ((int_request & ~mask_q) == 4'h0)
        else $error("request seen with its mask clear");
    a_pin_edge: assert property (s_pin_edge |-> ##[1:4] timer_tick)
        else $error("pin edge gave no tick in time");
    a_pin_quiet: assert property (s_pin_quiet |-> !timer_tick)
        else $error("tick without a pin edge");
endmodule // tps_front_assertions

bind tps_timer_front tps_front_assertions u_chk (
    .clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .count_pin(count_pin), .capture_event(capture_event), .timer_tick(timer_tick),
    .count_value(count_value), .int_request(int_request)
);

// File: tps_pulse_source.sv
// External pulse source driving the count pin.
// Assumes the bench calls burst from its main sequence only.
`timescale 1ns/100ps
module tps_pulse_source (
    clock,
    count_pin
);
    input wire logic clock;
    output logic count_pin;

    // Pin rests low between bursts, so the select may change
    initial count_pin = 1'b0;

    task automatic burst(input int pulses, input int half);
        if (half < 2)
            half = 2;
        repeat (pulses)
        begin
            @(posedge clock);
            count_pin <= 1'b1;
            repeat (half) @(posedge clock);
            count_pin <= 1'b0;
            repeat (half - 1) @(posedge clock);
        end
    endtask
endmodule // tps_pulse_source

// File: tb_tps_timer_front.sv
// Self-checking bench for the timer clock-select front end.
// Assumes the pulse source model alone drives the count pin.
`timescale 1ns/100ps
module tb_tps_timer_front;
    logic clock;
    logic reset_n;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_write;
    logic reg_read;
    logic [7:0] reg_rdata;
    logic count_pin;
    logic capture_event;
    logic timer_tick;
    logic [15:0] count_value;
    logic [3:0] int_request;
    int mismatches;
    int cmp_count;
    int n;
    int div[4] = '{8, 64, 256, 1024};

    tps_timer_front u_dut (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .count_pin(count_pin), .capture_event(capture_event),
        .timer_tick(timer_tick), .count_value(count_value), .int_request(int_request));
    tps_pulse_source u_src (.clock(clock), .count_pin(count_pin));

    initial clock = 1'b0;
    always #10 clock = ~clock;

    // ********************
    // Bus and check tasks
    // ********************
    task automatic conclude;
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge clock);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_read <= 1'b0;
        #1;
        check("read data", {8'h00, reg_rdata}, {8'h00, e});
    endtask

    // Bounded wait for the next tick; n counts edges
    task automatic wait_tick(input int bound, output int n);
        n = 0;
        do
        begin
            @(posedge clock);
            #1;
            n++;
        end
        while (timer_tick !== 1'b1 && n <= bound);
        if (n > bound)
        begin
            mismatches++;
            conclude();
        end
    endtask

    initial
    begin
        repeat (30000) @(posedge clock);
        mismatches++;
        conclude();
    end

    // ********************
    // Main sequence
    // ********************
    initial
    begin
        {reg_addr, reg_wdata, reg_write, reg_read, capture_event} = '0;
        reset_n = 1'b0;
        mismatches = 0;
        cmp_count = 0;
        repeat (5) @(posedge clock);
        reset_n <= 1'b1;
        for (int a = 0; a < 8; a++)
            rd(3'(a), 8'h00);
        wr(3'h7, 8'hFF);
        rd(3'h7, 8'h0F);
        wr(3'h1, 8'h19);
        wr(3'h2, 8'h00);
        repeat (20) @(posedge clock);
        rd(3'h2, 8'h00);
        rd(3'h1, 8'h19);
        wr(3'h1, 8'h09);
        rd(3'h1, 8'h01);
        repeat (4) @(posedge clock);
        wr(3'h1, 8'h00);
        rd(3'h2, 8'h07);
        for (int i = 0; i < 4; i++)
        begin
            wr(3'h1, 8'(i + 2));
            wait_tick(2 * div[i] + 2, n);
            check("first tick delay", 16'(n >= 1 && n <= div[i] + 1), 16'h0001);
            wait_tick(div[i] + 1, n);
            check("tick period", 16'(n), 16'(div[i]));
            wr(3'h1, 8'h00);
        end
        // Phase the prescaler far from its tap before resetting it
        wr(3'h1, 8'h05);
        wait_tick(1030, n);
        repeat (200) @(posedge clock);
        wr(3'h1, 8'h0D);
        wait_tick(1100, n);
        check("tick after prescaler reset", 16'(n > 1000), 16'h0001);
        wr(3'h1, 8'h00);
        wr(3'h2, 8'h00);
        // select switched only while the pin rests low
        wr(3'h1, 8'h07);
        u_src.burst(5, 2);
        repeat (6) @(posedge clock);
        wr(3'h1, 8'h06);
        u_src.burst(3, 3);
        repeat (6) @(posedge clock);
        wr(3'h1, 8'h00);
        rd(3'h2, 8'h08);
        wr(3'h6, 8'h0F);
        wr(3'h7, 8'h0F);
        wr(3'h2, 8'hFD);
        wr(3'h1, 8'h01);
        repeat (3) @(posedge clock);
        wr(3'h1, 8'h00);
        rd(3'h2, 8'h02);
        rd(3'h6, 8'h07);
        check("requests", {12'h000, int_request}, 16'h0007);
        wr(3'h7, 8'h01);
        #1;
        check("masked requests", {12'h000, int_request}, 16'h0001);
        wr(3'h6, 8'h07);
        rd(3'h6, 8'h00);
        wr(3'h4, 8'h03);
        wr(3'h5, 8'h04);
        wr(3'h1, 8'h01);
        repeat (8) @(posedge clock);
        wr(3'h1, 8'h00);
        rd(3'h6, 8'h06);
        wr(3'h0, 8'h80);
        wr(3'h6, 8'h0F);
        wr(3'h3, 8'h00);
        wr(3'h2, 8'hFE);
        wr(3'h4, 8'h02);
        wr(3'h5, 8'h01);
        wr(3'h1, 8'h01);
        repeat (8) @(posedge clock);
        wr(3'h1, 8'h00);
        rd(3'h3, 8'h01);
        check("count", count_value, 16'h0108);
        rd(3'h6, 8'h02);
        wr(3'h7, 8'h08);
        @(posedge clock);
        capture_event <= 1'b1;
        @(posedge clock);
        capture_event <= 1'b0;
        @(posedge clock);
        #1;
        check("capture request", {12'h000, int_request}, 16'h0008);
        wr(3'h0, 8'h00);
        wr(3'h1, 8'h01);
        wr(3'h2, 8'h40);
        wr(3'h1, 8'h00);
        rd(3'h2, 8'h43);
        conclude();
    end
endmodule // tb_tps_timer_front
